// file: hw/rlnc_pkg.sv
package rlnc_pkg;

    // ------------------------------------------------------------
    // Instruction encoding
    // ------------------------------------------------------------
    localparam logic [5:0] OPCODE = 6'h11;
    localparam int OPCODE_MSB = 15;
    localparam int OPCODE_LSB = 10;
    localparam int DEST_BIT = 9;
    localparam int ACCESS_BIT = 8;
    localparam int FILE_MSB = 7;

    // ------------------------------------------------------------
    // Data memory addressing
    // ------------------------------------------------------------
    localparam int ADDR_W = 14;
    localparam int BANK_W = 6;
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [7:0] INDEXED_MAX = 8'h5f;
    localparam logic [5:0] ACCESS_LOW_BANK = 6'h00;
    localparam logic [5:0] ACCESS_HIGH_BANK = 6'h3f;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] W_RESET = 8'h00;
    localparam logic [13:0] ADDR_RESET = 14'h0000;

    // ------------------------------------------------------------
    // Destination select
    // ------------------------------------------------------------
    localparam logic DEST_WORKING = 1'b0;
    localparam logic DEST_FILE = 1'b1;

    // ------------------------------------------------------------
    // Execution phases
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_DECODE = 5'h02,
        ST_READ = 5'h04,
        ST_PROCESS = 5'h08,
        ST_WRITE = 5'h10
    } rlnc_state_t;

endpackage : rlnc_pkg

// file: hw/rlnc_addr_if.sv
`timescale 1ns/10ps

interface rlnc_addr_if;
    logic [7:0] file_addr;
    logic access_sel;
    logic ext_enable;
    logic [rlnc_pkg::BANK_W-1:0] bank_select_register;
    logic [rlnc_pkg::ADDR_W-1:0] index_base;
    logic [rlnc_pkg::ADDR_W-1:0] full_addr;

    modport requester (
        output file_addr,
        output access_sel,
        output ext_enable,
        output bank_select_register,
        output index_base,
        input full_addr
    );

    modport resolver (
        input file_addr,
        input access_sel,
        input ext_enable,
        input bank_select_register,
        input index_base,
        output full_addr
    );
endinterface : rlnc_addr_if

// file: hw/rlnc_addr.sv
`timescale 1ns/10ps

module rlnc_addr (
    rlnc_addr_if.resolver ai
);

    logic use_indexed;
    logic low_access;

    // Indexed literal offset only applies in the access-bank form
    assign use_indexed = ai.ext_enable && !ai.access_sel
        && (ai.file_addr <= rlnc_pkg::INDEXED_MAX);
    assign low_access = ai.file_addr < rlnc_pkg::ACCESS_SPLIT;

    always_comb begin
        if (use_indexed) begin
            // Wraps at the top of data space, like the pointer it borrows
            ai.full_addr = 14'(ai.index_base + {6'h00, ai.file_addr});
        end else if (ai.access_sel) begin
            ai.full_addr = {ai.bank_select_register, ai.file_addr};
        end else if (low_access) begin
            ai.full_addr = {rlnc_pkg::ACCESS_LOW_BANK, ai.file_addr};
        end else begin
            ai.full_addr = {rlnc_pkg::ACCESS_HIGH_BANK, ai.file_addr};
        end
    end

endmodule : rlnc_addr

// file: hw/rlnc_exec.sv
`timescale 1ns/10ps


module rlnc_exec (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic exec_valid,
    input wire logic [15:0] instr,
    input wire logic ext_enable,
    input wire logic [rlnc_pkg::BANK_W-1:0] bank_select_register,
    input wire logic [rlnc_pkg::ADDR_W-1:0] index_base,
    input wire logic [7:0] mem_rd_data,
    output logic exec_ready,
    output logic illegal,
    output logic mem_rd_en,
    output logic [rlnc_pkg::ADDR_W-1:0] mem_addr,
    output logic mem_wr_en,
    output logic [7:0] mem_wr_data,
    output logic [7:0] working_reg,
    output logic status_n,
    output logic status_z,
    output logic status_we,
    output logic done
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    rlnc_pkg::rlnc_state_t state;
    rlnc_pkg::rlnc_state_t next_state;
    logic [15:0] instr_q;
    logic [7:0] operand;
    logic [7:0] next_result;
    logic dest_q;
    logic opcode_ok;
    logic take;

    rlnc_addr_if ai ();

    rlnc_addr u_addr (
        .ai(ai)
    );

    // Only the rotate opcode starts a sequence; anything else is refused
    assign opcode_ok = (instr[rlnc_pkg::OPCODE_MSB:rlnc_pkg::OPCODE_LSB]
        == rlnc_pkg::OPCODE);
    assign take = exec_valid && exec_ready;
    assign dest_q = instr_q[rlnc_pkg::DEST_BIT];

    // ------------------------------------------------------------
    // Address resolution
    // ------------------------------------------------------------
    // Address fields come from the held word, bank and base from the pins
    assign ai.file_addr = instr_q[rlnc_pkg::FILE_MSB:0];
    assign ai.access_sel = instr_q[rlnc_pkg::ACCESS_BIT];
    assign ai.ext_enable = ext_enable;
    assign ai.bank_select_register = bank_select_register;
    assign ai.index_base = index_base;

    // ------------------------------------------------------------
    // Phase sequencer: decode, read, process, write
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        unique case (state)
            rlnc_pkg::ST_IDLE: begin
                if (take && opcode_ok) begin
                    next_state = rlnc_pkg::ST_DECODE;
                end
            end
            rlnc_pkg::ST_DECODE: begin
                next_state = rlnc_pkg::ST_READ;
            end
            rlnc_pkg::ST_READ: begin
                next_state = rlnc_pkg::ST_PROCESS;
            end
            rlnc_pkg::ST_PROCESS: begin
                next_state = rlnc_pkg::ST_WRITE;
            end
            rlnc_pkg::ST_WRITE: begin
                next_state = rlnc_pkg::ST_IDLE;
            end
            // Only reachable from a corrupted one-hot code
            default: begin
                next_state = rlnc_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= rlnc_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            exec_ready <= 1'b0;
        end else begin
            // Ready again only once the write phase has retired
            exec_ready <= (next_state == rlnc_pkg::ST_IDLE);
        end
    end

    // ------------------------------------------------------------
    // Instruction capture
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            instr_q <= 16'h0000;
        end else if (take && opcode_ok) begin
            // Held for the whole sequence; the caller may change the word freely
            instr_q <= instr;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            illegal <= 1'b0;
        end else begin
            // Foreign opcodes are dropped, flagged for one cycle
            illegal <= take && !opcode_ok;
        end
    end

    // ------------------------------------------------------------
    // Operand read
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mem_addr <= rlnc_pkg::ADDR_RESET;
        end else if (state == rlnc_pkg::ST_DECODE) begin
            // Same address serves the read and the write back
            mem_addr <= ai.full_addr;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mem_rd_en <= 1'b0;
        end else begin
            // One strobe per instruction, aligned with the address
            mem_rd_en <= (state == rlnc_pkg::ST_DECODE);
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            operand <= 8'h00;
        end else if (state == rlnc_pkg::ST_READ) begin
            // Read data is taken while the strobe stands: no wait state,
            // so the memory must answer within the strobe cycle
            operand <= mem_rd_data;
        end
    end

    // ------------------------------------------------------------
    // Rotate
    // ------------------------------------------------------------
    // Bit 7 wraps into bit 0; carry is neither read nor written
    assign next_result = {operand[6:0], operand[7]};

    // ------------------------------------------------------------
    // Write to destination
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mem_wr_en <= 1'b0;
        end else begin
            mem_wr_en <= (state == rlnc_pkg::ST_PROCESS)
                && (dest_q == rlnc_pkg::DEST_FILE);
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mem_wr_data <= 8'h00;
        end else if (state == rlnc_pkg::ST_PROCESS) begin
            mem_wr_data <= next_result;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            working_reg <= rlnc_pkg::W_RESET;
        end else if ((state == rlnc_pkg::ST_PROCESS)
            && (dest_q == rlnc_pkg::DEST_WORKING)) begin
            working_reg <= next_result;
        end
    end

    // ------------------------------------------------------------
    // Status: negative and zero only; carry is left alone
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            status_n <= 1'b0;
            status_z <= 1'b0;
        end else if (state == rlnc_pkg::ST_PROCESS) begin
            status_n <= next_result[7];
            status_z <= (next_result == 8'h00);
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            status_we <= 1'b0;
            done <= 1'b0;
        end else begin
            // Same pulse twice: the core may route flag updates apart from retire
            status_we <= (state == rlnc_pkg::ST_PROCESS);
            done <= (state == rlnc_pkg::ST_PROCESS);
        end
    end

endmodule : rlnc_exec

// file: verification/rlnc_exec_checker.sv
`timescale 1ns/10ps

module rlnc_exec_checker (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic exec_valid,
    input wire logic [15:0] instr,
    input wire logic ext_enable,
    input wire logic [rlnc_pkg::BANK_W-1:0] bank_select_register,
    input wire logic [rlnc_pkg::ADDR_W-1:0] index_base,
    input wire logic [7:0] mem_rd_data,
    input wire logic exec_ready,
    input wire logic mem_rd_en,
    input wire logic [rlnc_pkg::ADDR_W-1:0] mem_addr,
    input wire logic mem_wr_en,
    input wire logic [7:0] mem_wr_data,
    input wire logic [7:0] working_reg,
    input wire logic status_n,
    input wire logic status_z,
    input wire logic done
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic tk;
    logic [7:0] fa;
    logic [7:0] rot;
    assign tk = exec_valid && exec_ready && instr[15:10] == 6'h11;
    assign fa = instr[7:0];
    assign rot = {mem_rd_data[6:0], mem_rd_data[7]};
    property p_busy;
        tk |=> !exec_ready [*4] ##1 exec_ready;
    endproperty
    a_busy: assert property (p_busy) else $error("busy window wrong");
    property p_wdat;
        mem_wr_en |-> mem_wr_data == $past(rot, 2);
    endproperty
    a_wdat: assert property (p_wdat) else $error("written byte wrong");
    property p_wrap;
        mem_wr_en |-> mem_wr_data[0] == $past(mem_rd_data[7], 2);
    endproperty
    a_wrap: assert property (p_wrap) else $error("top bit not wrapped");
    property p_flags;
        mem_rd_en |-> ##2 done && status_n == $past(mem_rd_data[6], 2)
            && status_z == ($past(mem_rd_data, 2) == 8'h00);
    endproperty
    a_flags: assert property (p_flags) else $error("flags wrong");
    property p_file;
        tk && instr[9] |-> ##4 mem_wr_en;
    endproperty
    a_file: assert property (p_file) else $error("no write back");
    property p_keepw;
        tk && instr[9] |-> ##4 $stable(working_reg);
    endproperty
    a_keepw: assert property (p_keepw) else $error("working reg disturbed");
    property p_work;
        tk && !instr[9] |-> ##4 !mem_wr_en && working_reg == $past(rot, 2);
    endproperty
    a_work: assert property (p_work) else $error("working reg wrong");
    property p_bank;
        tk && instr[8] |-> ##2 mem_addr == {$past(bank_select_register), $past(fa, 2)};
    endproperty
    a_bank: assert property (p_bank) else $error("banked address wrong");
    property p_acc;
        tk && !instr[8] ##1 !ext_enable |=>
            mem_addr == {($past(fa, 2) >= 8'h60) ? 6'h3f : 6'h00, $past(fa, 2)};
    endproperty
    a_acc: assert property (p_acc) else $error("access address wrong");
    property p_idx;
        tk && !instr[8] && fa <= 8'h5f ##1 ext_enable |=>
            mem_addr == $past(index_base) + $past(fa, 2);
    endproperty
    a_idx: assert property (p_idx) else $error("indexed address wrong");
    c_file: cover property (tk && instr[9]);
    c_work: cover property (tk && !instr[9]);
    c_idx: cover property (tk && !instr[8] && fa <= 8'h5f ##1 ext_enable);
endmodule : rlnc_exec_checker

bind rlnc_exec rlnc_exec_checker chk (
    .clock(clock),
    .rst_n(rst_n),
    .exec_valid(exec_valid),
    .instr(instr),
    .ext_enable(ext_enable),
    .bank_select_register(bank_select_register),
    .index_base(index_base),
    .mem_rd_data(mem_rd_data),
    .exec_ready(exec_ready),
    .mem_rd_en(mem_rd_en),
    .mem_addr(mem_addr),
    .mem_wr_en(mem_wr_en),
    .mem_wr_data(mem_wr_data),
    .working_reg(working_reg),
    .status_n(status_n),
    .status_z(status_z),
    .done(done)
);

// file: verification/testbench.sv
`timescale 1ns/10ps

module testbench;
    logic clock, rst_n, exec_valid, ext_enable;
    logic [15:0] instr;
    logic [5:0] bank_select_register;
    logic [13:0] index_base, mem_addr;
    logic [7:0] mem_rd_data, mem_wr_data, working_reg;
    logic exec_ready, illegal, mem_rd_en, mem_wr_en, status_n, status_z, status_we, done;
    int n_errors = 0;
    int num_checks = 0;
    rlnc_exec uut (
        .clock(clock),
        .rst_n(rst_n),
        .exec_valid(exec_valid),
        .instr(instr),
        .ext_enable(ext_enable),
        .bank_select_register(bank_select_register),
        .index_base(index_base),
        .mem_rd_data(mem_rd_data),
        .exec_ready(exec_ready),
        .illegal(illegal),
        .mem_rd_en(mem_rd_en),
        .mem_addr(mem_addr),
        .mem_wr_en(mem_wr_en),
        .mem_wr_data(mem_wr_data),
        .working_reg(working_reg),
        .status_n(status_n),
        .status_z(status_z),
        .status_we(status_we),
        .done(done)
    );
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    task final_report;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : final_report
    task chk(input logic [15:0] seen, input logic [15:0] want);
        num_checks++;
        if (seen !== want) begin
            n_errors++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, want);
        end
    endtask : chk
    function automatic logic [7:0] rotl(input logic [7:0] b);
        return {b[6:0], b[7]};
    endfunction : rotl
    function automatic logic [13:0] ea(input logic [15:0] i, input logic x,
        input logic [5:0] bs, input logic [13:0] ib);
        if (x && !i[8] && i[7:0] <= 8'h5f) return ib + 14'(i[7:0]);
        if (i[8]) return {bs, i[7:0]};
        return {(i[7:0] >= 8'h60) ? 6'h3f : 6'h00, i[7:0]};
    endfunction : ea
    task run(input logic [15:0] i, input logic x, input logic [7:0] dat);
        logic [5:0] bs;
        logic [13:0] ib;
        int k;
        bs = 6'($urandom);
        ib = 14'($urandom);
        k = 0;
        @(negedge clock);
        while (exec_ready !== 1'b1) begin
            k++;
            if (k > 20) begin
                n_errors++;
                final_report();
            end
            @(negedge clock);
        end
        @(posedge clock);
        exec_valid <= 1'b1;
        instr <= i;
        ext_enable <= x;
        bank_select_register <= bs;
        index_base <= ib;
        mem_rd_data <= ~dat;
        @(posedge clock);
        exec_valid <= 1'b0;
        if (i[15:10] != 6'h11) begin
            @(negedge clock);
            chk(illegal, 1'b1);
            chk(exec_ready, 1'b1);
            return;
        end
        @(posedge clock);
        mem_rd_data <= dat;
        @(negedge clock);
        chk(mem_rd_en, 1'b1);
        @(posedge clock);
        // Junk off the strobe cycle so an early or late sample shows
        mem_rd_data <= ~dat;
        ext_enable <= ~x;
        @(posedge clock);
        @(negedge clock);
        chk(done, 1'b1);
        chk(status_we, 1'b1);
        chk(mem_addr, ea(i, x, bs, ib));
        chk(status_n, dat[6]);
        chk(status_z, dat == 8'h00);
        chk(i[9] ? mem_wr_data : working_reg, rotl(dat));
        chk(mem_wr_en, i[9]);
    endtask : run
    initial begin
        rst_n = 1'b0;
        exec_valid = 1'b0;
        instr = 16'h0000;
        ext_enable = 1'b0;
        bank_select_register = 6'h00;
        index_base = 14'h0000;
        mem_rd_data = 8'h00;
        void'($urandom(86));
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        run({6'h11, 2'b10, 8'h5f}, 1'b1, 8'hab);
        run({6'h11, 2'b00, 8'h60}, 1'b1, 8'h80);
        run({6'h11, 2'b01, 8'h5f}, 1'b1, 8'h00);
        run({6'h11, 2'b11, 8'hff}, 1'b0, 8'h7f);
        run({6'h11, 2'b00, 8'h00}, 1'b0, 8'h01);
        run({6'h12, 2'b00, 8'h10}, 1'b0, 8'h01);
        $display("corner tests done");
        repeat (40) run({6'h11, 10'($urandom)}, 1'($urandom), 8'($urandom));
        $display("random tests done");
        final_report();
    end
endmodule : testbench
